// file: spcr_config_regs.sv
// spcr_config_regs.sv: serial port configuration and identification bank.
// assumes: a serial port engine on clk_sys_i gives byte-wide register
// strobes; the SPI/I2C mode select comes from a pin.
// Summary of operation
// - setting bit 7 of config A in SPI starts a full device reset
// - bit 6 of config A picks LSB first in SPI, ignored in I2C
// - bit 5 of config A steps addresses upward, else downward, SPI only
// - bit 4 of config A enables the separate data output pin, SPI only
// - config A bits 3..0 mirror bits 4..7 in pairs 3/4 2/5 1/6 0/7
// - each pair acts as the AND of both bits; host writes both alike
// - read buffer bit set: buffered registers read back the staged copy
// - read buffer bit clear: buffered registers read the active copy
// - config B bit 2 resets the device but keeps register contents
// - address 0x0003 bits 3..0 give a read-only device type code
// - address 0x0004 bits 7..4 give low part serial identifier bits
// - address 0x0005 gives upper eight part serial identifier bits
// - address 0x0006 gives a read-only die revision code
// - transfer register bit 0 copies staged values to active, self-clears
`timescale 1ns/1ps
`default_nettype none
`include "spcr_map.svh"
module spcr_config_regs #(
	parameter logic [3:0] DEVICE_TYPE = 4'h9, // arbitrary value
	parameter logic [11:0] PART_SERIAL = 12'h5A3, // arbitrary value
	parameter logic [7:0] DIE_REV = 8'h1C // arbitrary value
) (
	input wire logic clk_sys_i, // 125 MHz system clock
	input wire logic nrst_i, // sync reset, active low
	input wire logic spi_sel_i, // pin: 1 SPI, 0 I2C
	input wire logic [15:0] reg_addr_i, // register address
	input wire logic reg_wr_i, // write strobe
	input wire logic [7:0] reg_wdata_i, // write data
	input wire logic reg_rd_i, // read strobe
	output logic [7:0] reg_rdata_o, // read data
	output logic reg_rvalid_o, // read data valid pulse
	output logic lsb_first_o, // shift LSB first
	output logic addr_ascend_o, // step address upward
	output logic four_wire_select_o, // separate data output enabled
	output logic core_reset_o // device logic held in reset
);
	// ------------------------------------------------------------------
	// helpers
	// ------------------------------------------------------------------
	function automatic logic hit(input spcr_pkg::spcr_addr_t a,
		input spcr_pkg::spcr_addr_t ref_a);
		hit = (a == ref_a);
	endfunction

	function automatic spcr_pkg::spcr_byte_t pick(input logic sel,
		input spcr_pkg::spcr_byte_t stg, input spcr_pkg::spcr_byte_t act);
		pick = sel ? stg : act;
	endfunction

	// ------------------------------------------------------------------
	// mode pin synchroniser
	// ------------------------------------------------------------------
	logic spi_meta_reg;
	logic spi_reg;

	always_ff @(posedge clk_sys_i)
	begin
		if (!nrst_i)
		begin
			spi_meta_reg <= 1'b0;
			spi_reg <= 1'b0;
		end
		else
		begin
			spi_meta_reg <= spi_sel_i;
			spi_reg <= spi_meta_reg;
		end
	end

	// ------------------------------------------------------------------
	// write decode
	// ------------------------------------------------------------------
	logic full_busy;
	logic full_done;
	logic keep_busy;
	logic keep_done;
	logic wr_ok;
	logic wr_a;
	logic wr_b;
	logic wr_x;
	logic soft_go;
	logic keep_go;
	logic xfer_reg;
	logic [7:0] cfg_a_stg;
	logic [7:0] cfg_a_act;
	logic [7:0] cfg_b_stg;
	logic [7:0] cfg_b_act;
	logic [7:0] clr_b;

	// writes are dropped while a full reset runs; id addresses never decode
	assign wr_ok = reg_wr_i && !full_busy;
	assign wr_a = wr_ok && hit(reg_addr_i, `SPCR_ADDR_CFG_A);
	assign wr_b = wr_ok && hit(reg_addr_i, `SPCR_ADDR_CFG_B);
	assign wr_x = wr_ok && hit(reg_addr_i, `SPCR_ADDR_XFER);
	assign soft_go = wr_a && spi_reg && reg_wdata_i[`SPCR_A_SOFT_RST]
		&& reg_wdata_i[7 - `SPCR_A_SOFT_RST];
	assign keep_go = wr_b && reg_wdata_i[`SPCR_B_RST_KEEP] && !keep_busy;
	assign clr_b = keep_done ? `SPCR_CLR_B_KEEP : 8'h00;

	// transfer strobe lives one cycle, so the bit reads back cleared
	always_ff @(posedge clk_sys_i)
	begin
		if (!nrst_i)
			xfer_reg <= 1'b0;
		else
			xfer_reg <= wr_x && reg_wdata_i[`SPCR_XFER_GO];
	end

	// ------------------------------------------------------------------
	// buffered configuration registers
	// ------------------------------------------------------------------
	spcr_stage_reg #(
		.RST_VAL(`SPCR_RST_CFG_A)
	) u_cfg_a (
		.clk_sys_i(clk_sys_i),
		.nrst_i(nrst_i),
		.wr_i(wr_a),
		.wdata_i(reg_wdata_i),
		.xfer_i(xfer_reg),
		.init_i(full_done),
		.clr_mask_i(8'h00),
		.staged_o(cfg_a_stg),
		.active_o(cfg_a_act)
	);

	spcr_stage_reg #(
		.RST_VAL(`SPCR_RST_CFG_B)
	) u_cfg_b (
		.clk_sys_i(clk_sys_i),
		.nrst_i(nrst_i),
		.wr_i(wr_b),
		.wdata_i(reg_wdata_i),
		.xfer_i(xfer_reg),
		.init_i(full_done),
		.clr_mask_i(clr_b),
		.staged_o(cfg_b_stg),
		.active_o(cfg_b_act)
	);

	// ------------------------------------------------------------------
	// reset sequencers
	// ------------------------------------------------------------------
	spcr_reset_seq u_full_rst (
		.clk_sys_i(clk_sys_i),
		.nrst_i(nrst_i),
		.start_i(soft_go && !full_busy),
		.busy_o(full_busy),
		.done_o(full_done)
	);

	spcr_reset_seq u_keep_rst (
		.clk_sys_i(clk_sys_i),
		.nrst_i(nrst_i),
		.start_i(keep_go),
		.busy_o(keep_busy),
		.done_o(keep_done)
	);

	always_ff @(posedge clk_sys_i)
	begin
		if (!nrst_i)
			core_reset_o <= 1'b0;
		else
			core_reset_o <= full_busy || keep_busy || soft_go || keep_go;
	end

	// ------------------------------------------------------------------
	// mirrored pairs and port controls
	// ------------------------------------------------------------------
	logic [3:0] pair_on;

	generate
		for (genvar i = 0; i < 4; i++)
		begin : g_pair
			assign pair_on[i] = cfg_a_act[4 + i] & cfg_a_act[3 - i];
		end
	endgenerate

	always_ff @(posedge clk_sys_i)
	begin
		if (!nrst_i)
		begin
			lsb_first_o <= 1'b0;
			addr_ascend_o <= 1'b0;
			four_wire_select_o <= 1'b0;
		end
		else
		begin
			lsb_first_o <= spi_reg && pair_on[`SPCR_A_LSB_FIRST - 4];
			addr_ascend_o <= spi_reg && pair_on[`SPCR_A_ADDR_ASC - 4];
			four_wire_select_o <= spi_reg && pair_on[`SPCR_A_FOUR_WIRE - 4];
		end
	end

	// ------------------------------------------------------------------
	// readback
	// ------------------------------------------------------------------
	logic rd_buf;

	assign rd_buf = cfg_b_stg[`SPCR_B_READ_BUF];

	always_ff @(posedge clk_sys_i)
	begin
		if (!nrst_i)
			reg_rvalid_o <= 1'b0;
		else
			reg_rvalid_o <= reg_rd_i;
	end

	always_ff @(posedge clk_sys_i)
	begin
		if (!nrst_i)
			reg_rdata_o <= 8'h00;
		else if (reg_rd_i)
		begin
			unique case (reg_addr_i)
				`SPCR_ADDR_CFG_A:
					reg_rdata_o <= pick(rd_buf, cfg_a_stg, cfg_a_act);
				`SPCR_ADDR_CFG_B:
					reg_rdata_o <= pick(rd_buf, cfg_b_stg, cfg_b_act);
				`SPCR_ADDR_TYPE:
					reg_rdata_o <= {4'h0, DEVICE_TYPE};
				`SPCR_ADDR_SER_LO:
					reg_rdata_o <= {PART_SERIAL[3:0], 4'h0};
				`SPCR_ADDR_SER_HI:
					reg_rdata_o <= PART_SERIAL[11:4];
				`SPCR_ADDR_REV:
					reg_rdata_o <= DIE_REV;
				`SPCR_ADDR_XFER:
					reg_rdata_o <= {7'h00, xfer_reg};
				default:
					reg_rdata_o <= 8'h00;
			endcase
		end
	end

	// ------------------------------------------------------------------
	// checks
	// ------------------------------------------------------------------
	default clocking cb @(posedge clk_sys_i);
	endclocking
	default disable iff (!nrst_i);

	sequence s_soft_wr;
		wr_a && spi_reg && reg_wdata_i[7] && reg_wdata_i[0] && !full_busy;
	endsequence

	sequence s_keep_wr;
		wr_b && reg_wdata_i[2] && !keep_busy && !full_busy;
	endsequence

	sequence s_rd_a;
		reg_rd_i && hit(reg_addr_i, `SPCR_ADDR_CFG_A);
	endsequence

	chk_soft_reset_go: assert property (
		s_soft_wr |=> core_reset_o ##1 full_busy [*7] ##1 full_done)
		else $error("soft reset did not run its hold");

	chk_order_i2c: assert property (
		!spi_reg |=> !lsb_first_o && !addr_ascend_o && !four_wire_select_o)
		else $error("port control active in I2C mode");

	chk_ascend_follow: assert property (
		spi_reg && cfg_a_act[5] && cfg_a_act[2] && $stable(spi_reg)
		|=> addr_ascend_o)
		else $error("address stepping does not follow config A");

	chk_four_wire: assert property (
		xfer_reg && spi_reg && cfg_a_stg[4] && cfg_a_stg[3]
		|=> ##1 four_wire_select_o || !spi_reg)
		else $error("four wire select missed after transfer");

	chk_pair_and: assert property (
		cfg_a_act[6] != cfg_a_act[1] |=> !lsb_first_o)
		else $error("half pair turned lsb first on");

	chk_pair_both: assert property (
		spi_reg && $past(spi_reg) && cfg_a_act[6] && cfg_a_act[1]
		|=> lsb_first_o)
		else $error("full pair did not turn lsb first on");

	chk_read_staged: assert property (
		s_rd_a and rd_buf |=> reg_rvalid_o && reg_rdata_o == $past(cfg_a_stg))
		else $error("staged readback wrong");

	chk_read_active: assert property (
		s_rd_a and !rd_buf |=> reg_rdata_o == $past(cfg_a_act))
		else $error("active readback wrong");

	chk_keep_regs: assert property (
		s_keep_wr ##1 (!wr_a) |-> $stable(cfg_a_stg) && core_reset_o)
		else $error("keep reset lost register contents");

	chk_type_code: assert property (
		reg_rd_i && reg_addr_i == `SPCR_ADDR_TYPE
		|=> reg_rdata_o == {4'h0, DEVICE_TYPE})
		else $error("device type readback wrong");

	chk_serial_id: assert property (
		reg_rd_i && reg_addr_i == `SPCR_ADDR_SER_LO
		|=> reg_rdata_o == {PART_SERIAL[3:0], 4'h0})
		else $error("serial id low readback wrong");

	chk_serial_hi: assert property (
		reg_rd_i && reg_addr_i == `SPCR_ADDR_SER_HI
		|=> reg_rdata_o == PART_SERIAL[11:4])
		else $error("serial id high readback wrong");

	chk_die_rev: assert property (
		reg_rd_i && reg_addr_i == `SPCR_ADDR_REV |=> reg_rdata_o == DIE_REV)
		else $error("die revision readback wrong");

	chk_xfer_copy: assert property (
		wr_x && reg_wdata_i[0] && !full_done
		|=> xfer_reg ##1 !xfer_reg && cfg_a_act == $past(cfg_a_stg & 8'hFF, 1)
			|| $past(wr_a) || $past(full_done))
		else $error("transfer did not copy staged values");

	chk_id_ro: assert property (
		reg_wr_i && reg_addr_i == `SPCR_ADDR_SER_HI
		|=> $stable(cfg_a_stg) && $stable(cfg_b_stg))
		else $error("id write disturbed configuration");

	chk_self_clear: assert property (
		keep_done && !wr_b |=> !cfg_b_stg[2] && !cfg_b_act[2])
		else $error("keep reset bit did not clear");

	chk_soft_clear: assert property (
		s_soft_wr |-> ##[9:10] cfg_a_stg == `SPCR_RST_CFG_A)
		else $error("soft reset bits did not clear");

	chk_wr_blocked: assert property (
		full_busy && reg_wr_i && !keep_done |=> $stable(cfg_a_stg) && $stable(cfg_b_stg))
		else $error("write landed during full reset");

	chk_core_release: assert property (
		full_done && !keep_busy && !keep_go && !soft_go |=> !core_reset_o)
		else $error("core reset held after full reset ended");
endmodule // spcr_config_regs
`default_nettype wire

// file: spcr_map.svh
// spcr_map.svh: offsets, field positions, reset values and timing counts
// of the serial port configuration and identification register bank.
// assumes: included by bare name; a 125 MHz system clock.
`ifndef SPCR_MAP_SVH
`define SPCR_MAP_SVH

// ----------------------------------------------------------------------
// register offsets
// ----------------------------------------------------------------------
`define SPCR_ADDR_CFG_A 16'h0000
`define SPCR_ADDR_CFG_B 16'h0001
`define SPCR_ADDR_TYPE 16'h0003
`define SPCR_ADDR_SER_LO 16'h0004
`define SPCR_ADDR_SER_HI 16'h0005
`define SPCR_ADDR_REV 16'h0006
`define SPCR_ADDR_XFER 16'h000F

// ----------------------------------------------------------------------
// field positions
// ----------------------------------------------------------------------
`define SPCR_A_SOFT_RST 7
`define SPCR_A_LSB_FIRST 6
`define SPCR_A_ADDR_ASC 5
`define SPCR_A_FOUR_WIRE 4
`define SPCR_B_READ_BUF 5
`define SPCR_B_RST_KEEP 2
`define SPCR_XFER_GO 0

// ----------------------------------------------------------------------
// reset values
// ----------------------------------------------------------------------
`define SPCR_RST_CFG_A 8'h00
`define SPCR_RST_CFG_B 8'h00
`define SPCR_CLR_B_KEEP 8'h04

// ----------------------------------------------------------------------
// timing
// ----------------------------------------------------------------------
`define SPCR_CLK_NS 8
`define SPCR_RST_HOLD_NS 64
`define SPCR_RST_CYC ((`SPCR_RST_HOLD_NS + `SPCR_CLK_NS - 1) / `SPCR_CLK_NS)

`endif

// file: spcr_pkg.sv
// spcr_pkg.sv: types of the serial port configuration register bank.
// assumes: nothing; holds types only.
`default_nettype none
package spcr_pkg;
	typedef enum logic [1:0]
	{
		SPCR_RS_IDLE = 2'b00,
		SPCR_RS_HOLD = 2'b01,
		SPCR_RS_DONE = 2'b10
	} spcr_rst_state_t;

	typedef logic [15:0] spcr_addr_t;
	typedef logic [7:0] spcr_byte_t;
endpackage
`default_nettype wire

// file: spcr_stage_reg.sv
// spcr_stage_reg.sv: one buffered register, staged copy plus active copy.
// assumes: write, transfer and init strobes come from the same clock.
`timescale 1ns/1ps
`default_nettype none
module spcr_stage_reg #(
	parameter logic [7:0] RST_VAL = 8'h00
) (
	input wire logic clk_sys_i, // system clock
	input wire logic nrst_i, // sync reset, active low
	input wire logic wr_i, // host write strobe
	input wire logic [7:0] wdata_i, // host write data
	input wire logic xfer_i, // staged to active transfer
	input wire logic init_i, // return both copies to reset value
	input wire logic [7:0] clr_mask_i, // self-clearing bits to drop
	output logic [7:0] staged_o, // staged copy
	output logic [7:0] active_o // copy driving the logic
);
	// a host write in the clearing cycle wins over the clear
	always_ff @(posedge clk_sys_i)
	begin
		if (!nrst_i || init_i)
			staged_o <= RST_VAL;
		else if (wr_i)
			staged_o <= wdata_i;
		else
			staged_o <= staged_o & ~clr_mask_i;
	end

	always_ff @(posedge clk_sys_i)
	begin
		if (!nrst_i || init_i)
			active_o <= RST_VAL;
		else if (xfer_i)
			active_o <= staged_o & ~clr_mask_i;
		else
			active_o <= active_o & ~clr_mask_i;
	end
endmodule // spcr_stage_reg
`default_nettype wire

// file: spcr_reset_seq.sv
// spcr_reset_seq.sv: holds a reset for a fixed count, then pulses done.
// assumes: start is a one-cycle strobe on the system clock.
`timescale 1ns/1ps
`default_nettype none
`include "spcr_map.svh"
module spcr_reset_seq (
	input wire logic clk_sys_i, // system clock
	input wire logic nrst_i, // sync reset, active low
	input wire logic start_i, // start a reset
	output logic busy_o, // reset in progress
	output logic done_o // one cycle after the hold ends
);
	localparam int HOLD = `SPCR_RST_CYC;
	spcr_pkg::spcr_rst_state_t state_reg;
	logic [7:0] cnt_reg;

	always_ff @(posedge clk_sys_i)
	begin
		if (!nrst_i)
		begin
			state_reg <= spcr_pkg::SPCR_RS_IDLE;
			cnt_reg <= 8'h00;
		end
		else
		begin
			unique case (state_reg)
				spcr_pkg::SPCR_RS_IDLE:
				begin
					if (start_i)
					begin
						state_reg <= spcr_pkg::SPCR_RS_HOLD;
						cnt_reg <= 8'(HOLD - 1);
					end
				end
				spcr_pkg::SPCR_RS_HOLD:
				begin
					if (cnt_reg == 8'h00)
						state_reg <= spcr_pkg::SPCR_RS_DONE;
					else
						cnt_reg <= cnt_reg - 8'h01;
				end
				spcr_pkg::SPCR_RS_DONE:
					state_reg <= spcr_pkg::SPCR_RS_IDLE;
				default:
					state_reg <= spcr_pkg::SPCR_RS_IDLE;
			endcase
		end
	end

	assign busy_o = (state_reg == spcr_pkg::SPCR_RS_HOLD);
	assign done_o = (state_reg == spcr_pkg::SPCR_RS_DONE);
endmodule // spcr_reset_seq
`default_nettype wire

// file: spcr_host_model.sv
// spcr_host_model.sv: host controller side of the register port.
// assumes: byte strobes on the system clock, driven at the falling edge.
`timescale 1ns/1ps
`default_nettype none
module spcr_host_model (
	input wire logic clk_sys_i, // system clock
	output logic [15:0] reg_addr_o, // register address
	output logic reg_wr_o, // write strobe
	output logic [7:0] reg_wdata_o, // write data
	output logic reg_rd_o, // read strobe
	input wire logic [7:0] reg_rdata_i, // read data
	input wire logic reg_rvalid_i // read data valid
);
	initial
	begin
		reg_addr_o = 16'hFFFF;
		reg_wr_o = 1'b0;
		reg_wdata_o = 8'hA5;
		reg_rd_o = 1'b0;
	end

	// ------------------------------------------------------------------
	// byte write: one strobe, lines scrambled once released
	// ------------------------------------------------------------------
	task automatic wr_byte(input logic [15:0] a, input logic [7:0] d);
	begin
		@(negedge clk_sys_i);
		reg_addr_o = a;
		reg_wdata_o = d;
		reg_wr_o = 1'b1;
		@(negedge clk_sys_i);
		reg_wr_o = 1'b0;
		reg_addr_o = ~a;
		reg_wdata_o = ~d;
	end
	endtask

	// ------------------------------------------------------------------
	// byte read: answer sampled half a cycle after the taking edge
	// ------------------------------------------------------------------
	task automatic rd_byte(input logic [15:0] a, output logic [7:0] d, output logic ok);
	begin
		@(negedge clk_sys_i);
		reg_addr_o = a;
		reg_rd_o = 1'b1;
		@(negedge clk_sys_i);
		reg_rd_o = 1'b0;
		reg_addr_o = ~a;
		ok = reg_rvalid_i;
		d = reg_rdata_i;
	end
	endtask
endmodule // spcr_host_model
`default_nettype wire

// file: spcr_config_regs_tb.sv
// spcr_config_regs_tb.sv: self-checking bench of the register bank.
// assumes: the host model drives the register port; model uses ints.
`timescale 1ns/1ps
`default_nettype none
module spcr_config_regs_tb;
	localparam logic [3:0] TYPE_P = 4'h6; // arbitrary value
	localparam logic [11:0] SER_P = 12'hB27; // arbitrary value
	localparam logic [7:0] REV_P = 8'h4D; // arbitrary value
	logic clk_sys_i = 1'b0;
	logic nrst_i = 1'b0;
	logic spi_sel_i = 1'b1;
	logic [15:0] reg_addr;
	logic reg_wr;
	logic [7:0] reg_wdata;
	logic reg_rd;
	logic [7:0] reg_rdata;
	logic reg_rvalid;
	logic lsb_first;
	logic addr_ascend;
	logic four_wire;
	logic core_reset;
	int errors = 0;
	int n_tests = 0;
	int cycles = 0;
	int sa = 0;
	int sb = 0;
	int aa = 0;
	int ab = 0;
	int i;
	int k;
	logic [7:0] d;
	logic [2:0] m;

	always #4 clk_sys_i = ~clk_sys_i;

	spcr_host_model host (.clk_sys_i(clk_sys_i), .reg_addr_o(reg_addr), .reg_wr_o(reg_wr),
		.reg_wdata_o(reg_wdata), .reg_rd_o(reg_rd), .reg_rdata_i(reg_rdata),
		.reg_rvalid_i(reg_rvalid));

	spcr_config_regs #(.DEVICE_TYPE(TYPE_P), .PART_SERIAL(SER_P), .DIE_REV(REV_P)) uut (
		.clk_sys_i(clk_sys_i), .nrst_i(nrst_i), .spi_sel_i(spi_sel_i),
		.reg_addr_i(reg_addr), .reg_wr_i(reg_wr), .reg_wdata_i(reg_wdata),
		.reg_rd_i(reg_rd), .reg_rdata_o(reg_rdata), .reg_rvalid_o(reg_rvalid),
		.lsb_first_o(lsb_first), .addr_ascend_o(addr_ascend),
		.four_wire_select_o(four_wire), .core_reset_o(core_reset));

	// ------------------------------------------------------------------
	// comparison and closing
	// ------------------------------------------------------------------
	task automatic check(input logic [7:0] got, input logic [7:0] exp);
	begin
		n_tests++;
		if (got !== exp)
		begin
			errors++;
			$display("wrong value at %0t: got %h expected %h", $time, got, exp);
		end
	end
	endtask

	task automatic cmp_data(input logic [7:0] got, input logic [7:0] exp);
		check(got, exp);
	endtask

	task automatic cmp_ctl(input logic [2:0] got, input logic [2:0] exp);
		check({5'h00, got}, {5'h00, exp});
	endtask

	task automatic cmp_flag(input logic got, input logic exp);
		check({7'h00, got}, {7'h00, exp});
	endtask

	task automatic report_and_stop;
	begin
		$display("errors=%0d n_tests=%0d", errors, n_tests);
		if (errors == 0 && n_tests > 0)
			$display("Testbench passed");
		else
			$display("Testbench failed");
		$finish;
	end
	endtask

	always @(posedge clk_sys_i)
	begin
		cycles++;
		if (cycles == 6000)
		begin
			errors++;
			report_and_stop;
		end
	end

	// ------------------------------------------------------------------
	// reference model
	// ------------------------------------------------------------------
	function automatic logic [7:0] exp_rd(input int a);
		case (a)
			0: return 8'(sb[5] ? sa : aa);
			1: return 8'(sb[5] ? sb : ab);
			3: return {4'h0, TYPE_P};
			4: return {SER_P[3:0], 4'h0};
			5: return SER_P[11:4];
			6: return REV_P;
			default: return 8'h00;
		endcase
	endfunction

	function automatic logic [2:0] exp_ctl();
		if (!spi_sel_i)
			return 3'b000;
		return {aa[6] & aa[1], aa[5] & aa[2], aa[4] & aa[3]};
	endfunction

	task automatic rd_chk(input int a);
		logic [7:0] v;
		logic ok;
	begin
		host.rd_byte(16'(a), v, ok);
		cmp_flag(ok, 1'b1);
		cmp_data(v, exp_rd(a));
	end
	endtask

	task automatic wait_reset;
		int n;
	begin
		n = 0;
		cmp_flag(core_reset, 1'b1);
		while (core_reset === 1'b1 && n < 40)
		begin
			@(negedge clk_sys_i);
			n++;
		end
		cmp_flag(n >= 6 && n <= 12, 1'b1);
	end
	endtask

	// ------------------------------------------------------------------
	// main sequence
	// ------------------------------------------------------------------
	initial
	begin
		void'($urandom(50107));
		repeat (6) @(negedge clk_sys_i);
		nrst_i = 1'b1;
		repeat (3) @(negedge clk_sys_i);
		cmp_ctl({lsb_first, addr_ascend, four_wire}, 3'b000);
		for (i = 0; i < 8; i++)
			rd_chk(i);
		for (i = 3; i < 7; i++)
		begin
			host.wr_byte(16'(i), 8'($urandom));
			rd_chk(i);
		end
		rd_chk(16'h0002);
		for (k = 0; k < 12; k++)
		begin
			m = 3'($urandom);
			d = {1'b0, m[2], m[1], m[0], m[0], m[1], m[2], 1'b0};
			if (k % 3 == 2)
				d = d ^ (8'($urandom) & 8'h0E);
			host.wr_byte(16'h0000, d);
			sa = d;
			d = 8'($urandom) & 8'hFB;
			host.wr_byte(16'h0001, d);
			sb = d;
			rd_chk(0);
			rd_chk(1);
			host.wr_byte(16'h000F, 8'h01);
			aa = sa;
			ab = sb;
			repeat (4) @(negedge clk_sys_i);
			cmp_ctl({lsb_first, addr_ascend, four_wire}, exp_ctl());
			rd_chk(16'h000F);
			rd_chk(0);
			spi_sel_i = 1'b0;
			repeat (4) @(negedge clk_sys_i);
			cmp_ctl({lsb_first, addr_ascend, four_wire}, exp_ctl());
			spi_sel_i = 1'b1;
			repeat (4) @(negedge clk_sys_i);
		end
		host.wr_byte(16'h0001, 8'(sb | 8'h04));
		wait_reset;
		rd_chk(0);
		rd_chk(1);
		cmp_ctl({lsb_first, addr_ascend, four_wire}, exp_ctl());
		host.wr_byte(16'h0000, 8'h81);
		host.wr_byte(16'h0001, 8'h20);
		wait_reset;
		sa = 0;
		sb = 0;
		aa = 0;
		ab = 0;
		rd_chk(0);
		rd_chk(1);
		cmp_ctl({lsb_first, addr_ascend, four_wire}, 3'b000);
		report_and_stop;
	end
endmodule // spcr_config_regs_tb
`default_nettype wire
